/* hdl/dcd_cfg.svh */
`ifndef DCD_CFG_SVH
`define DCD_CFG_SVH
`define DCD_OFS_CTRL       14'h1c00
`define DCD_OFS_GSX        14'h1ce8
`define DCD_OFS_GSY        14'h1cec
`define DCD_OFS_BACC       14'h1cf0
`define DCD_OFS_BSX        14'h1cf8
`define DCD_OFS_BSY        14'h1cfc
`define DCD_SLOPE_W        24
`define DCD_OPC_LO         0
`define DCD_ATY_LO         4
`define DCD_LIN_BIT        7
`define DCD_ZM_LO          8
`define DCD_SOLID_BIT      11
`define DCD_ARZ_BIT        12
`define DCD_SGZ_BIT        13
`define DCD_SHZ_BIT        14
`define DCD_BOP_LO         16
`define DCD_TRN_LO         20
`define DCD_BLT_LO         25
`define DCD_PAT_BIT        29
`define DCD_TRC_BIT        30
`define DCD_BOP_COPY       4'hc
`define DCD_SRC_ONES       32'hffffffff
`define DCD_MASK_OPAQUE    16'hffff
`endif

/* hdl/dcd_pkg.sv */
package dcd_pkg;
	typedef enum logic [3:0] {
		DCD_OP_LINE_OPEN  = 4'h0,
		DCD_OP_AUTO_OPEN  = 4'h1,
		DCD_OP_LINE_CLOSE = 4'h2,
		DCD_OP_AUTO_CLOSE = 4'h3,
		DCD_OP_TRAP       = 4'h4,
		DCD_OP_TEX_TRAP   = 4'h5,
		DCD_OP_BLIT       = 4'h8,
		DCD_OP_HOST_LOAD  = 4'h9,
		DCD_OP_DUMP       = 4'ha,
		DCD_OP_FBLIT      = 4'hc,
		DCD_OP_LOAD_SCALE = 4'hd,
		DCD_OP_LOAD_FILT  = 4'hf
	} dcd_opcode_t;

	typedef enum logic [2:0] {
		DCD_AT_REPLACE = 3'h0,
		DCD_AT_RASTER  = 3'h1,
		DCD_AT_DEPTH   = 3'h3,
		DCD_AT_BLOCK   = 3'h4,
		DCD_AT_SHADE   = 3'h7
	} dcd_atype_t;

	typedef enum logic [1:0] {
		DCD_CL_LINE = 2'h0,
		DCD_CL_TRAP = 2'h1,
		DCD_CL_BLIT = 2'h3,
		DCD_CL_RSVD = 2'h2
	} dcd_class_t;

	typedef struct packed {
		dcd_class_t op_class;
		logic       auto_line;
		logic       last_pixel;
		logic       texture;
		logic       mem_to_mem;
		logic       host_to_memory_blit;
		logic       memory_to_host_blit;
		logic       op_reserved;
	} dcd_op_t;

	typedef struct packed {
		logic       plain_replace_write;
		logic       raster_rmw;
		logic       depth_shade;
		logic       block_write_access;
		logic       shade_zcmp;
		logic       at_reserved;
	} dcd_acc_t;

	typedef struct packed {
		logic [2:0] zmode;
		logic       z_always;
		logic       z_reserved;
	} dcd_z_t;

	typedef struct packed {
		logic       mono;
		logic       mono_word_order;
		logic       mono_plane;
		logic       fmt_colour;
		logic       luma_chroma;
		logic       bpp32;
		logic       bpp24;
		logic       red_first;
		logic       fmt_reserved;
	} dcd_fmt_t;

	typedef struct packed {
		logic        valid;
		logic [13:0] addr;
		logic [31:0] data;
	} dcd_wr_t;
endpackage : dcd_pkg

/* hdl/dcd_bool_unit.sv */
`timescale 1ns/10ps
`include "dcd_cfg.svh"
module dcd_bool_unit #(
	parameter int W = 32
) (
	input  wire logic [3:0]   bop,
	input  wire logic         force_copy,
	input  wire logic [W-1:0] dst,
	input  wire logic [W-1:0] src,
	output logic      [W-1:0] res
);
	logic [3:0] code;

	// Block write forces replace regardless of code  (see R7)
	assign code = force_copy ? `DCD_BOP_COPY : bop;

	// Code bit index = {S,D}: truth-table form covers all 16  (see R17)
	always_comb begin
		for (int i = 0; i < W; i++) begin
			res[i] = code[{src[i], dst[i]}];
		end
	end
endmodule : dcd_bool_unit

/* hdl/dcd_trans_mask.sv */
`timescale 1ns/10ps
`include "dcd_cfg.svh"
module dcd_trans_mask (
	input  wire logic [3:0]  trans,
	input  wire logic [1:0]  px_x,
	input  wire logic [1:0]  px_y,
	output logic             write_en,
	output logic      [15:0] mask
);
	// Fixed 4x4 pattern; more set bits means more opaque  (see R22)
	always_comb begin
		case (trans)
			4'h0: mask = `DCD_MASK_OPAQUE;
			4'h1: mask = 16'h7fff;
			4'h2: mask = 16'h7bde;
			4'h3: mask = 16'h5bda;
			4'h4: mask = 16'h5a5a;
			4'h5: mask = 16'h5a4a;
			4'h6: mask = 16'h4a4a;
			4'h7: mask = 16'h4a42;
			4'h8: mask = 16'h4242;
			4'h9: mask = 16'h4240;
			4'ha: mask = 16'h4040;
			4'hb: mask = 16'h0440;
			4'hc: mask = 16'h0400;
			4'hd: mask = 16'h0401;
			4'he: mask = 16'h0001;
			default: mask = 16'h8000;
		endcase
	end

	// Unmasked pixels are skipped, not written  (see R19)
	assign write_en = mask[{px_y, px_x}];
endmodule : dcd_trans_mask

/* hdl/dcd_drawing_control.sv */
`timescale 1ns/10ps
`include "dcd_cfg.svh"
// Summary of operation
// R1 - Slopes keep signed 9.15 low 24 bits
// R2 - Green slopes: x/y or major/diagonal steps
// R3 - Blue accumulator: start blue, current pixel
// R4 - Blue slopes: x/y or major/diagonal steps
// R5 - Decode four-bit operation code
// R6 - Decode access type bits 6:4
// R7 - Block write forces plain replace
// R8 - Bit 7 selects linear addressing
// R9 - Decode depth compare mode bits 10:8
// R10 - Solid alias loads pattern words ones
// R11 - Address clear zeroes all except three
// R12 - Software drops address clear before access
// R13 - Sign clear zeroes every sign field
// R14 - Software drops sign clear before writing
// R15 - Shift clear zeroes the shift register
// R16 - Software drops shift clear before access
// R17 - Boolean unit combines D and S
// R18 - Software uses source copy in block
// R19 - Translucency writes one of n pixels
// R20 - Decode blit source format bits 28:25
// R21 - Control word field placement
// R22 - Translucency selects 4x4 mask, zero opaque
// R23 - Bit 29 patterning, bit 30 transparent background
module dcd_drawing_control #(
	parameter int DATA_W = 32
) (
	input  wire logic                 clock,
	input  wire logic                 rstn,
	input  wire dcd_pkg::dcd_wr_t     wr,
	input  wire logic [DATA_W-1:0]    pix_dst,
	input  wire logic [DATA_W-1:0]    pix_src,
	input  wire logic [1:0]           pix_x,
	input  wire logic [1:0]           pix_y,
	output logic      [31:0]          ctrl_word_r,
	output dcd_pkg::dcd_op_t          op_dec_r,
	output dcd_pkg::dcd_acc_t         acc_dec_r,
	output dcd_pkg::dcd_z_t           z_dec_r,
	output dcd_pkg::dcd_fmt_t         fmt_dec_r,
	output logic                      linear_r,
	output logic [3:0]                bop_r,
	output logic [3:0]                trans_r,
	output logic                      pattern_en_r,
	output logic                      bg_transparent_r,
	output logic [23:0]               green_slope_x_major_r,
	output logic [23:0]               green_slope_y_diagonal_r,
	output logic [23:0]               blue_edge_accumulator_r,
	output logic [23:0]               blue_slope_x_major_r,
	output logic [23:0]               blue_slope_y_diagonal_r,
	output logic                      source_pattern_fill_r,
	output logic                      address_register_clear_r,
	output logic                      sign_register_clear_r,
	output logic                      shift_register_clear_r,
	output logic                      blue_step_active_r,
	output logic                      blue_step_diag_r,
	output logic [DATA_W-1:0]         pix_result_r,
	output logic                      pix_write_r
);
	// ************************************************************
	// Decode functions
	// ************************************************************
	function automatic dcd_pkg::dcd_op_t dec_op(input logic [3:0] c);
		dcd_pkg::dcd_op_t o;
		o = '0;
		case (c)
			4'h0, 4'h1, 4'h2, 4'h3: begin
				o.op_class   = dcd_pkg::DCD_CL_LINE;
				o.auto_line  = c[0];
				o.last_pixel = c[1];
			end
			4'h4, 4'h5: begin
				o.op_class = dcd_pkg::DCD_CL_TRAP;
				o.texture  = c[0];
			end
			4'h8, 4'hc: begin
				o.op_class   = dcd_pkg::DCD_CL_BLIT;
				o.mem_to_mem = 1'b1;
			end
			4'h9, 4'hd, 4'hf: begin
				o.op_class            = dcd_pkg::DCD_CL_BLIT;
				o.host_to_memory_blit = 1'b1;
			end
			4'ha: begin
				o.op_class            = dcd_pkg::DCD_CL_BLIT;
				o.memory_to_host_blit = 1'b1;
			end
			default: begin
				o.op_class    = dcd_pkg::DCD_CL_RSVD;
				o.op_reserved = 1'b1;
			end
		endcase
		return o; // see R5
	endfunction : dec_op

	function automatic dcd_pkg::dcd_acc_t dec_acc(input logic [2:0] a);
		dcd_pkg::dcd_acc_t r;
		r = '0;
		case (a)
			dcd_pkg::DCD_AT_REPLACE: r.plain_replace_write = 1'b1;
			dcd_pkg::DCD_AT_RASTER:  r.raster_rmw          = 1'b1;
			dcd_pkg::DCD_AT_DEPTH:   r.depth_shade         = 1'b1;
			dcd_pkg::DCD_AT_BLOCK:   r.block_write_access  = 1'b1;
			dcd_pkg::DCD_AT_SHADE:   r.shade_zcmp          = 1'b1;
			default:                 r.at_reserved         = 1'b1;
		endcase
		return r; // see R6
	endfunction : dec_acc

	function automatic dcd_pkg::dcd_z_t dec_z(input logic [2:0] z);
		dcd_pkg::dcd_z_t r;
		r            = '0;
		r.zmode      = z;
		r.z_always   = (z == 3'h0);
		r.z_reserved = (z == 3'h1);
		return r; // see R9
	endfunction : dec_z

	function automatic dcd_pkg::dcd_fmt_t dec_fmt(input logic [3:0] b);
		dcd_pkg::dcd_fmt_t r;
		r = '0;
		case (b)
			4'h0: r.mono = 1'b1;
			4'h4: begin
				r.mono            = 1'b1;
				r.mono_word_order = 1'b1;
			end
			4'h1: r.mono_plane  = 1'b1;
			4'h2: r.fmt_colour  = 1'b1;
			4'he: r.luma_chroma = 1'b1;
			4'h3: r.bpp32       = 1'b1;
			4'h7: begin
				r.bpp32     = 1'b1;
				r.red_first = 1'b1;
			end
			4'hb: r.bpp24 = 1'b1;
			4'hf: begin
				r.bpp24     = 1'b1;
				r.red_first = 1'b1;
			end
			default: r.fmt_reserved = 1'b1;
		endcase
		return r; // see R20
	endfunction : dec_fmt

	// ************************************************************
	// Write strobes
	// ************************************************************
	logic wr_ctrl;
	logic wr_gsx;
	logic wr_gsy;
	logic wr_bacc;
	logic wr_bsx;
	logic wr_bsy;

	assign wr_ctrl = wr.valid && (wr.addr == `DCD_OFS_CTRL);
	assign wr_gsx  = wr.valid && (wr.addr == `DCD_OFS_GSX);
	assign wr_gsy  = wr.valid && (wr.addr == `DCD_OFS_GSY);
	assign wr_bacc = wr.valid && (wr.addr == `DCD_OFS_BACC);
	assign wr_bsx  = wr.valid && (wr.addr == `DCD_OFS_BSX);
	assign wr_bsy  = wr.valid && (wr.addr == `DCD_OFS_BSY);

	// ************************************************************
	// Drawing control word and decodes
	// ************************************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl_word_r      <= 32'h0;
			op_dec_r         <= '0;
			acc_dec_r        <= '0;
			z_dec_r          <= '0;
			fmt_dec_r        <= '0;
			linear_r         <= 1'b0;
			bop_r            <= 4'h0;
			trans_r          <= 4'h0;
			pattern_en_r     <= 1'b0;
			bg_transparent_r <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl_word_r      <= wr.data;
			op_dec_r         <= dec_op(wr.data[`DCD_OPC_LO +: 4]); // see R21
			acc_dec_r        <= dec_acc(wr.data[`DCD_ATY_LO +: 3]);
			z_dec_r          <= dec_z(wr.data[`DCD_ZM_LO +: 3]);
			fmt_dec_r        <= dec_fmt(wr.data[`DCD_BLT_LO +: 4]);
			linear_r         <= wr.data[`DCD_LIN_BIT]; // see R8
			bop_r            <= wr.data[`DCD_BOP_LO +: 4]; // see R21
			trans_r          <= wr.data[`DCD_TRN_LO +: 4];
			pattern_en_r     <= wr.data[`DCD_PAT_BIT]; // see R23
			bg_transparent_r <= wr.data[`DCD_TRC_BIT];
		end
	end

	// ************************************************************
	// Alias pulses toward neighbouring register files
	// ************************************************************
	// One-cycle pulses; writing zero produces nothing
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			source_pattern_fill_r    <= 1'b0;
			address_register_clear_r <= 1'b0;
			sign_register_clear_r    <= 1'b0;
			shift_register_clear_r   <= 1'b0;
		end else begin
			source_pattern_fill_r    <= wr_ctrl && wr.data[`DCD_SOLID_BIT]; // see R10
			address_register_clear_r <= wr_ctrl && wr.data[`DCD_ARZ_BIT]; // see R11
			sign_register_clear_r    <= wr_ctrl && wr.data[`DCD_SGZ_BIT]; // see R13
			shift_register_clear_r   <= wr_ctrl && wr.data[`DCD_SHZ_BIT]; // see R15
		end
	end

	// ************************************************************
	// Colour slope data registers
	// ************************************************************
	// Upper byte of the bus word is dropped  (see R1)
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			green_slope_x_major_r    <= 24'h0;
			green_slope_y_diagonal_r <= 24'h0;
		end else begin
			if (wr_gsx) begin
				green_slope_x_major_r <= wr.data[`DCD_SLOPE_W-1:0]; // see R2
			end
			if (wr_gsy) begin
				green_slope_y_diagonal_r <= wr.data[`DCD_SLOPE_W-1:0];
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			blue_slope_x_major_r    <= 24'h0;
			blue_slope_y_diagonal_r <= 24'h0;
		end else begin
			if (wr_bsx) begin
				blue_slope_x_major_r <= wr.data[`DCD_SLOPE_W-1:0]; // see R4
			end
			if (wr_bsy) begin
				blue_slope_y_diagonal_r <= wr.data[`DCD_SLOPE_W-1:0];
			end
		end
	end

	// Blue stepping: x/major or y/diagonal; unused for texture traps
	logic blue_step_en;
	assign blue_step_en = (acc_dec_r.depth_shade || acc_dec_r.shade_zcmp) && !op_dec_r.texture
		&& (op_dec_r.op_class == dcd_pkg::DCD_CL_LINE || op_dec_r.op_class == dcd_pkg::DCD_CL_TRAP);

	// Accumulator steps by one slope per pixel cycle when enabled
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			blue_edge_accumulator_r <= 24'h0;
			blue_step_active_r      <= 1'b0;
			blue_step_diag_r        <= 1'b0;
		end else begin
			blue_step_active_r <= blue_step_en; // see R4
			blue_step_diag_r   <= pix_y[0];
			if (wr_bacc) begin
				blue_edge_accumulator_r <= wr.data[`DCD_SLOPE_W-1:0]; // see R3
			end else if (blue_step_en) begin
				blue_edge_accumulator_r <= blue_edge_accumulator_r
					+ (pix_y[0] ? blue_slope_y_diagonal_r : blue_slope_x_major_r); // see R3
			end
		end
	end

	// ************************************************************
	// Pixel datapath: boolean unit and translucency
	// ************************************************************
	logic [DATA_W-1:0] bool_res;
	logic              trans_we;

	dcd_bool_unit #(
		.W(DATA_W)
	) u_bool (
		.bop        (bop_r),
		.force_copy (acc_dec_r.block_write_access), // see R7
		.dst        (pix_dst),
		.src        (pix_src),
		.res        (bool_res)
	);

	dcd_trans_mask u_mask (
		.trans    (trans_r),
		.px_x     (pix_x),
		.px_y     (pix_y),
		.write_en (trans_we),
		.mask     ()
	);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pix_result_r <= '0;
			pix_write_r  <= 1'b0;
		end else begin
			pix_result_r <= bool_res; // see R17
			pix_write_r  <= trans_we; // see R19
		end
	end
endmodule : dcd_drawing_control

/* verification/dcd_drawing_control_assertions.sv */
`timescale 1ns/10ps
`include "dcd_cfg.svh"
module dcd_drawing_control_checker #(
	parameter int DATA_W = 32
) (
	input wire logic              clock,
	input wire logic              rstn,
	input wire dcd_pkg::dcd_wr_t  wr,
	input wire logic [DATA_W-1:0] pix_dst,
	input wire logic [DATA_W-1:0] pix_src,
	input wire logic [31:0]       ctrl_word_r,
	input wire dcd_pkg::dcd_acc_t acc_dec_r,
	input wire logic [3:0]        bop_r,
	input wire logic [3:0]        trans_r,
	input wire logic [23:0]       green_slope_x_major_r,
	input wire logic [23:0]       blue_slope_y_diagonal_r,
	input wire logic              source_pattern_fill_r,
	input wire logic              address_register_clear_r,
	input wire logic              sign_register_clear_r,
	input wire logic              shift_register_clear_r,
	input wire logic [DATA_W-1:0] pix_result_r,
	input wire logic              pix_write_r
);
	// ****
	// Helpers
	// ****
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	logic              ctl_wr;
	logic [DATA_W-1:0] bool_exp;
	assign ctl_wr = wr.valid && wr.addr == `DCD_OFS_CTRL;
	// Block write ignores the boolean code and copies the source
	assign bool_exp = acc_dec_r.block_write_access ? pix_src :
		({DATA_W{bop_r[0]}} & ~pix_src & ~pix_dst) | ({DATA_W{bop_r[1]}} & ~pix_src & pix_dst) |
		({DATA_W{bop_r[2]}} & pix_src & ~pix_dst) | ({DATA_W{bop_r[3]}} & pix_src & pix_dst);
	// ****
	// Assertions
	// ****
	chk_ctrl_load: assert property (ctl_wr |=> ctrl_word_r == $past(wr.data))
		else $error("control word not loaded");
	chk_slope_trim: assert property (wr.valid && wr.addr == `DCD_OFS_GSX |=>
		green_slope_x_major_r == $past(wr.data[23:0])) else $error("slope not loaded with low bits");
	chk_slope_hold: assert property (!(wr.valid && wr.addr == `DCD_OFS_BSY) |=>
		$stable(blue_slope_y_diagonal_r)) else $error("slope changed without its write");
	chk_fill_pulse: assert property (source_pattern_fill_r == $past(ctl_wr && wr.data[11]))
		else $error("fill pulse wrong");
	chk_addr_clear: assert property (address_register_clear_r == $past(ctl_wr && wr.data[12]))
		else $error("address clear pulse wrong");
	chk_sign_clear: assert property (ctl_wr && wr.data[13] |=> sign_register_clear_r ##1
		(sign_register_clear_r == $past(ctl_wr && wr.data[13]))) else $error("sign clear pulse wrong");
	chk_shift_clear: assert property (shift_register_clear_r == $past(ctl_wr && wr.data[14]))
		else $error("shift clear pulse wrong");
	chk_bop_trans: assert property (ctl_wr |=> bop_r == $past(wr.data[19:16]) &&
		trans_r == $past(wr.data[23:20])) else $error("boolean or translucency field wrong");
	chk_bool_result: assert property ($past(rstn) |-> pix_result_r == $past(bool_exp))
		else $error("boolean result wrong");
	chk_opaque_write: assert property ($past(rstn) && $past(trans_r) == 4'h0 |-> pix_write_r)
		else $error("opaque pixel not written");
	// ****
	// Covers
	// ****
	cov_fill: cover property (ctl_wr && wr.data[11]);
	cov_block: cover property (acc_dec_r.block_write_access);
	cov_skip: cover property (trans_r != 4'h0 && !pix_write_r);
endmodule : dcd_drawing_control_checker

bind dcd_drawing_control dcd_drawing_control_checker #(.DATA_W(DATA_W)) u_chk (.clock, .rstn, .wr, .pix_dst,
	.pix_src, .ctrl_word_r, .acc_dec_r, .bop_r, .trans_r, .green_slope_x_major_r, .blue_slope_y_diagonal_r,
	.source_pattern_fill_r, .address_register_clear_r, .sign_register_clear_r, .shift_register_clear_r,
	.pix_result_r, .pix_write_r);

/* verification/dcd_drawing_control_tb.sv */
`timescale 1ns/10ps
`include "dcd_cfg.svh"
module dcd_drawing_control_tb;
	typedef struct packed {
		logic [8:0] op;
		logic [5:0] acc;
		logic [8:0] fmt;
	} dcd_row_t;
	logic              clock;
	logic              rstn;
	dcd_pkg::dcd_wr_t  wr;
	logic [31:0]       pix_dst;
	logic [31:0]       pix_src;
	logic [1:0]        pix_x;
	logic [1:0]        pix_y;
	logic [31:0]       ctrl_word_r;
	dcd_pkg::dcd_op_t  op_dec_r;
	dcd_pkg::dcd_acc_t acc_dec_r;
	dcd_pkg::dcd_z_t   z_dec_r;
	dcd_pkg::dcd_fmt_t fmt_dec_r;
	logic              linear_r;
	logic [3:0]        bop_r;
	logic [3:0]        trans_r;
	logic              pattern_en_r;
	logic              bg_transparent_r;
	logic [23:0]       green_slope_x_major_r;
	logic [23:0]       green_slope_y_diagonal_r;
	logic [23:0]       blue_edge_accumulator_r;
	logic [23:0]       blue_slope_x_major_r;
	logic [23:0]       blue_slope_y_diagonal_r;
	logic              source_pattern_fill_r;
	logic              address_register_clear_r;
	logic              sign_register_clear_r;
	logic              shift_register_clear_r;
	logic              blue_step_active_r;
	logic              blue_step_diag_r;
	logic [31:0]       pix_result_r;
	logic              pix_write_r;
	int                mismatches;
	int                n_checks;
	int                cnt;
	logic [3:0]        pulses;
	assign pulses = {source_pattern_fill_r, address_register_clear_r, sign_register_clear_r, shift_register_clear_r};
	// Expected op, access and source-format decodes for code i in every field
	dcd_row_t rows [16] = '{
		'{9'h000, 6'h20, 9'h100}, '{9'h040, 6'h10, 9'h040}, '{9'h020, 6'h01, 9'h020}, '{9'h060, 6'h08, 9'h008},
		'{9'h080, 6'h04, 9'h180}, '{9'h090, 6'h01, 9'h001}, '{9'h101, 6'h01, 9'h001}, '{9'h101, 6'h02, 9'h00a},
		'{9'h188, 6'h20, 9'h001}, '{9'h184, 6'h10, 9'h001}, '{9'h182, 6'h01, 9'h001}, '{9'h101, 6'h08, 9'h004},
		'{9'h188, 6'h04, 9'h001}, '{9'h184, 6'h01, 9'h001}, '{9'h101, 6'h01, 9'h010}, '{9'h184, 6'h02, 9'h006}};

	dcd_drawing_control dut (.clock, .rstn, .wr, .pix_dst, .pix_src, .pix_x, .pix_y, .ctrl_word_r, .op_dec_r,
		.acc_dec_r, .z_dec_r, .fmt_dec_r, .linear_r, .bop_r, .trans_r, .pattern_en_r, .bg_transparent_r,
		.green_slope_x_major_r, .green_slope_y_diagonal_r, .blue_edge_accumulator_r, .blue_slope_x_major_r,
		.blue_slope_y_diagonal_r, .source_pattern_fill_r, .address_register_clear_r, .sign_register_clear_r,
		.shift_register_clear_r, .blue_step_active_r, .blue_step_diag_r, .pix_result_r, .pix_write_r);

	// ****
	// Tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic put(input logic [13:0] a, input logic [31:0] d);
		@(negedge clock);
		wr = '{1'b1, a, d};
	endtask : put

	task automatic idle();
		@(negedge clock);
		wr.valid = 1'b0;
	endtask : idle

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	function automatic logic [31:0] exp_bool(input logic [3:0] b, input logic [31:0] d, input logic [31:0] s);
		exp_bool = {32{b[0]}} & ~s & ~d | {32{b[1]}} & ~s & d | {32{b[2]}} & s & ~d | {32{b[3]}} & s & d;
	endfunction : exp_bool

	// ****
	// Stimulus
	// ****
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Cuts a hang short
	initial begin
		#200000;
		mismatches++;
		give_verdict();
	end

	initial begin
		wr = '0;
		pix_dst = 32'h0f0f_3355;
		pix_src = 32'h00ff_5533;
		pix_x = 2'h0;
		pix_y = 2'h0;
		rstn = 1'b0;
		mismatches = 0;
		n_checks = 0;
		repeat (2) @(negedge clock);
		rstn = 1'b1;
		check(ctrl_word_r, 32'h0);
		for (int i = 0; i < 16; i++) begin
			put(`DCD_OFS_CTRL, {1'b0, i[2], i[1], i[3:0], 1'b0, i[3:0], i[3:0], 5'h00, i[2:0], i[0], i[2:0], i[3:0]});
			idle();
			check(op_dec_r, rows[i].op);
			check(acc_dec_r, rows[i].acc);
			check(z_dec_r, {i[2:0], i[2:0] == 3'h0, i[2:0] == 3'h1});
			check(fmt_dec_r, rows[i].fmt);
			check({pattern_en_r, bg_transparent_r, linear_r, bop_r, trans_r},
				{i[1], i[2], i[0], i[3:0], i[3:0]});
			check(pulses, 4'h0);
		end
		// Back-to-back slope writes with junk in the upper byte, then two unmapped writes
		put(`DCD_OFS_CTRL, 32'h0);
		put(`DCD_OFS_GSX, 32'hff80_0001);
		put(`DCD_OFS_GSY, 32'h7f12_3456);
		put(`DCD_OFS_BACC, 32'h8000_0100);
		put(`DCD_OFS_BSX, 32'h5500_0010);
		put(`DCD_OFS_BSY, 32'haa00_1000);
		put(14'h1cf4, 32'hffff_ffff);
		put(14'h1c04, 32'hffff_ffff);
		idle();
		check(green_slope_x_major_r, 24'h800001);
		check(green_slope_y_diagonal_r, 24'h123456);
		check(blue_edge_accumulator_r, 24'h000100);
		check(blue_slope_x_major_r, 24'h000010);
		check(blue_slope_y_diagonal_r, 24'h001000);
		check(ctrl_word_r, 32'h0);
		// Depth-shaded trapezoid: accumulator steps by x, then by y slope
		put(`DCD_OFS_CTRL, 32'h0000_0034);
		put(`DCD_OFS_BACC, 32'h0);
		idle();
		check(blue_edge_accumulator_r, 24'h0);
		@(negedge clock);
		pix_y = 2'h1;
		check(blue_edge_accumulator_r, 24'h000010);
		check({blue_step_active_r, blue_step_diag_r}, 2'h2);
		@(negedge clock);
		check(blue_edge_accumulator_r, 24'h001010);
		check({blue_step_active_r, blue_step_diag_r}, 2'h3);
		put(`DCD_OFS_CTRL, 32'h0);
		pix_y = 2'h0;
		// One alias bit at a time, each a single-cycle pulse
		for (int k = 0; k < 4; k++) begin
			put(`DCD_OFS_CTRL, 32'h800 << k);
			idle();
			check(pulses, 4'h8 >> k);
			@(negedge clock);
			check(pulses, 4'h0);
		end
		// Each of the 16 boolean codes at zero translucency, result and write checked
		put(`DCD_OFS_CTRL, 32'h0);
		for (int b = 0; b < 16; b++) begin
			put(`DCD_OFS_CTRL, {12'h000, b[3:0], 16'h0000});
			idle();
			@(negedge clock);
			check(pix_result_r, exp_bool(b[3:0], pix_dst, pix_src));
			check(pix_write_r, 1'b1);
		end
		// Block write with a zero boolean code still copies the source
		put(`DCD_OFS_CTRL, 32'h0000_0040);
		idle();
		@(negedge clock);
		check(pix_result_r, pix_src);
		// Block write with the source-copy code software is meant to use
		put(`DCD_OFS_CTRL, 32'h000c_0040);
		idle();
		@(negedge clock);
		check(pix_result_r, pix_src);
		// Sparsest translucency over a 4x4 tile
		put(`DCD_OFS_CTRL, 32'h00f0_0000);
		idle();
		cnt = 0;
		for (int p = 0; p < 17; p++) begin
			@(negedge clock);
			if (p > 0)
				cnt += int'(pix_write_r);
			pix_x = p[1:0];
			pix_y = p[3:2];
		end
		check(cnt > 0 && cnt < 16, 1'b1);
		// Mid-run reset with every alias bit pending and stepping armed
		put(`DCD_OFS_CTRL, 32'h0000_7834);
		idle();
		check(pulses, 4'hf);
		rstn = 1'b0;
		@(negedge clock);
		rstn = 1'b1;
		check(ctrl_word_r, 32'h0);
		check(pulses, 4'h0);
		check({blue_step_active_r, blue_step_diag_r, blue_edge_accumulator_r}, 26'h0);
		check(pix_result_r, 32'h0);
		put(`DCD_OFS_GSX, 32'hff00_0abc);
		idle();
		check(green_slope_x_major_r, 24'h000abc);
		give_verdict();
	end
endmodule : dcd_drawing_control_tb
